// *** common/cdb_regs.svh ***
// register map, reset values, character codes and timing of the call detect block
// assumes a 32-bit bus with one register to an aligned word
`ifndef CDB_REGS_SVH
`define CDB_REGS_SVH
`define CDB_A_LINK    8'h00
`define CDB_A_MODE    8'h04
`define CDB_A_PIN     8'h08
`define CDB_A_STAT    8'h0c
`define CDB_A_LEN     8'h10
`define CDB_A_PAT     8'h20
`define CDB_A_INI     8'h30
`define CDB_F_DEFAULT 8
`define CDB_F_START   8
`define CDB_F_PINSET  16
`define CDB_LINK_RST  5'h00
`define CDB_RING_RST  5'h01
`define CDB_RING_MAX  5'h14
`define CDB_DLY_MAX   4'ha
`define CDB_PAT_MAX   28
`define CDB_INI_MAX   16
`define CDB_CH_PLUS   4'ha
`define CDB_CH_MINUS  4'hb
`define CDB_CH_STAR   4'hc
`define CDB_ASC_CR    8'h0d
`define CDB_ASC_QUOTE 8'h22
`define CDB_ASC_ZERO  8'h30
`define CDB_PIN_CMD   64'h3d4e_4950_432b_5441
`define CDB_CLK_HZ    200000000
`define CDB_BAUD_LO   9600
`define CDB_BAUD_HI   19200
`endif

// *** common/cdb_pkg.sv ***
// types shared by the call detect block and its link transmitter
// constants live in cdb_regs.svh
package cdb_pkg;
  typedef enum logic [1:0] {PAR_NONE, PAR_ODD, PAR_EVEN} cdb_parity_e;
  typedef struct packed {
    logic        baud_hi;
    logic        stop2;
    cdb_parity_e parity;
    logic        char7;
  } cdb_link_s;
  // caller events from the modem receive path, same clock
  typedef struct packed {
    logic       ring;
    logic       digit_vld;
    logic [3:0] digit;
    logic       num_end;
    logic       hangup;
  } cdb_call_s;
  typedef enum logic [1:0] {SEQ_DELAY, SEQ_INIT, SEQ_PIN, SEQ_DONE} cdb_seq_e;
endpackage : cdb_pkg

// *** core/cdb_matcher.sv ***
// compares the caller number, one digit at a time, with the stored pattern
// assumes digits arrive between hangup and num_end on the same clock
`timescale 1ns/1ps
`include "cdb_regs.svh"
module cdb_matcher #(
  parameter int PAT_MAX = `CDB_PAT_MAX
) (
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire logic [4*PAT_MAX-1:0] pat,
  input  wire logic [4:0]           pat_len,
  input  wire cdb_pkg::cdb_call_s   call,
  output logic                      match,
  output logic                      done
);
  import cdb_pkg::*;
  logic [4:0] idx_reg;
  logic       dead_reg;
  logic       wild_reg;
  logic       extra_reg;
  logic [3:0] p;
  assign p = pat[4*idx_reg +: 4];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      idx_reg   <= 5'h00;
      dead_reg  <= 1'b0;
      wild_reg  <= 1'b0;
      extra_reg <= 1'b0;
    end else if (call.hangup) begin
      idx_reg   <= 5'h00;
      dead_reg  <= 1'b0;
      wild_reg  <= 1'b0;
      extra_reg <= 1'b0;
    end else if (call.digit_vld && !done && !dead_reg) begin
      if (wild_reg) begin
        extra_reg <= 1'b1;
      end else if (idx_reg < pat_len && p == `CDB_CH_STAR) begin
        wild_reg  <= 1'b1;
        extra_reg <= 1'b1;
      end else if (idx_reg >= pat_len || p != call.digit) begin
        dead_reg <= 1'b1;
      end else begin
        idx_reg <= idx_reg + 5'h01;
      end
    end
  end

  // result stands from num_end until hangup; later digits are ignored
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      done  <= 1'b0;
      match <= 1'b0;
    end else if (call.hangup) begin
      done  <= 1'b0;
      match <= 1'b0;
    end else if (call.num_end && !done) begin
      done  <= 1'b1;
      match <= pat_len != 5'h00 && !dead_reg &&
               (wild_reg ? extra_reg : idx_reg == pat_len);
    end
  end
endmodule : cdb_matcher

// *** core/cdb_uart_tx.sv ***
// serial transmitter towards the modem with selectable frame format
// assumes cfg is steady while a character is on the line
`timescale 1ns/1ps
`include "cdb_regs.svh"
module cdb_uart_tx #(
  parameter int CLK_HZ = `CDB_CLK_HZ
) (
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire cdb_pkg::cdb_link_s cfg,
  input  wire logic               tx_valid,
  input  wire logic [7:0]         tx_data,
  output logic                    tx_ready,
  output logic                    txd
);
  import cdb_pkg::*;
  localparam int DIV_LO = CLK_HZ / `CDB_BAUD_LO;
  localparam int DIV_HI = CLK_HZ / `CDB_BAUD_HI;
  logic [15:0] bcnt_reg;
  logic [11:0] sh_reg;
  logic [3:0]  left_reg;
  logic [11:0] f;
  logic [3:0]  n;
  logic [3:0]  pos;
  logic [3:0]  tot;
  logic [7:0]  dm;
  logic [15:0] div;

  assign tx_ready = left_reg == 4'h0;
  assign div = cfg.baud_hi ? 16'(DIV_HI - 1) : 16'(DIV_LO - 1);

  always_comb begin
    f   = 12'hfff;
    f[0] = 1'b0;
    n   = cfg.char7 ? 4'h7 : 4'h8;
    dm  = cfg.char7 ? {1'b0, tx_data[6:0]} : tx_data;
    for (int i = 0; i < 8; i++) begin
      if (i < int'(n)) f[i+1] = dm[i];
    end
    pos = n + 4'h1;
    if (cfg.parity != PAR_NONE) begin
      f[pos] = (cfg.parity == PAR_ODD) ? ~^dm : ^dm;
      pos    = pos + 4'h1;
    end
    tot = pos + (cfg.stop2 ? 4'h2 : 4'h1);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sh_reg   <= 12'hfff;
      left_reg <= 4'h0;
      bcnt_reg <= 16'h0000;
      txd      <= 1'b1;
    end else if (tx_ready && tx_valid) begin
      sh_reg   <= f;
      left_reg <= tot;
      bcnt_reg <= div;
      txd      <= 1'b0;
    end else if (!tx_ready) begin
      if (bcnt_reg == 16'h0000) begin
        sh_reg   <= {1'b1, sh_reg[11:1]};
        left_reg <= left_reg - 4'h1;
        bcnt_reg <= div;
        txd      <= (left_reg == 4'h1) ? 1'b1 : sh_reg[1];
      end else begin
        bcnt_reg <= bcnt_reg - 16'h0001;
      end
    end
  end
endmodule : cdb_uart_tx

// *** core/cdb_call_detect.sv ***
// call detect function unit with modem link settings, AHB-Lite register slave
// assumes caller events and unit inputs come from logic on hclk
//
// Summary of operation
// - output goes high when enabled and the caller matches the pattern
// - with enable low the output holds and matching calls are ignored
// - reset input forces the output low
// - with retention the output is restored after power returns
// - pattern holds up to 28 characters: plus, minus, asterisk, digits
// - asterisk at the end or alone stands for one or more further digits
// - lone asterisk matches all callers; plus asterisk all international ones
// - a call is detected after a ring count of 1 to 20, shared
// - link character length selectable as 7 or 8 bits
// - link parity selectable as none, odd or even
// - link stop bits selectable as one or two
// - a user initialization command string is sent to the modem
// - with quoting on, the PIN is sent inside quotation marks
// - Remote_permit access needs GSM mode, permission and a PIN
// - a standard modem allows remote operation but never sends messages
// - link bit rate selectable as 9600 or 19200
// - defaults are 8 bits, no parity, one stop bit, 9600
// - wait 0 to 10 seconds after power-up before initialization; the code counts the wait from a start write to MODE and waits none after reset
//
// The register addresses and the AHB-Lite register port are this design's own decisions.
`timescale 1ns/1ps
`include "cdb_regs.svh"
module cdb_call_detect #(
  parameter int CLK_HZ     = `CDB_CLK_HZ,
  parameter int SEC_CYCLES = `CDB_CLK_HZ
) (
  input  wire logic               hclk,
  input  wire logic               hresetn,
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic [31:0]             hrdata,
  output logic                    hreadyout,
  output logic                    hresp,
  input  wire cdb_pkg::cdb_call_s call,
  input  wire logic               enable_in,
  input  wire logic               reset_in,
  input  wire logic               retain_en,
  input  wire logic               nv_out_in,
  output logic                    fu_out,
  output logic                    call_detect,
  output logic                    remote_ok,
  output logic                    sms_ok,
  output logic                    modem_txd
);
  import cdb_pkg::*;
  localparam logic [63:0] PIN_CMD = `CDB_PIN_CMD;

  // bus slave state
  logic        a_vld_reg;
  logic        a_wr_reg;
  logic [7:0]  a_off_reg;
  logic        take;
  logic        wr;
  logic [31:0] rd_val;
  // software registers
  cdb_link_s   link_reg;
  logic        gsm_reg;
  logic        permit_reg;
  logic        quote_reg;
  logic [3:0]  delay_reg;
  logic [4:0]  ring_lim_reg;
  logic [15:0] pin_reg;
  logic        pin_set_reg;
  logic [4:0]  pat_len_reg;
  logic [4:0]  ini_len_reg;
  logic [31:0] pat_w [4];
  logic [31:0] ini_w [4];
  logic [127:0] pat_flat;
  // call and output state
  logic [4:0]  ring_cnt_reg;
  logic        fired_reg;
  logic        boot_reg;
  logic        match;
  logic        match_done;
  logic        detect;
  // initialization sequencer
  cdb_seq_e    seq_reg;
  logic [27:0] sec_cnt_reg;
  logic [3:0]  s_cnt_reg;
  logic [4:0]  idx_reg;
  logic        tx_valid;
  logic        tx_ready;
  logic [7:0]  tx_byte;
  logic        tx_last;

  function automatic logic [7:0] pin_byte(input logic [4:0] i, input logic q,
                                          input logic [15:0] pin);
    logic [4:0] k;
    k = i;
    if (q) k = (i > 5'h0d) ? i - 5'h02 : (i > 5'h08) ? i - 5'h01 : i;
    if (q && (i == 5'h08 || i == 5'h0d)) return `CDB_ASC_QUOTE;
    if (k < 5'h08) return PIN_CMD[{k[2:0], 3'h0} +: 8];
    if (k < 5'h0c) return `CDB_ASC_ZERO + {4'h0, pin[{k[1:0], 2'h0} +: 4]};
    return `CDB_ASC_CR;
  endfunction : pin_byte

  function automatic logic [4:0] clamp5(input logic [4:0] v);
    if (v == 5'h00) return 5'h01;
    return (v > `CDB_RING_MAX) ? `CDB_RING_MAX : v;
  endfunction : clamp5

  // ---------------- AHB-Lite slave, zero wait states, always OKAY
  assign take      = hsel && htrans[1] && hready;
  assign wr        = a_vld_reg && a_wr_reg;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      a_vld_reg <= 1'b0;
      a_wr_reg  <= 1'b0;
      a_off_reg <= 8'h00;
    end else begin
      a_vld_reg <= take;
      a_wr_reg  <= hwrite;
      a_off_reg <= haddr[7:0];
    end
  end

  always_comb begin
    rd_val = 32'h0000_0000;
    if (haddr[31:8] == 24'h00_0000) begin
      unique case (haddr[7:0])
        `CDB_A_LINK: rd_val = {27'h000_0000, link_reg};
        `CDB_A_MODE: rd_val = {3'h0, ring_lim_reg, 4'h0, delay_reg, 13'h0000,
                               quote_reg, permit_reg, gsm_reg};
        `CDB_A_PIN:  rd_val = {15'h0000, pin_set_reg, pin_reg};
        `CDB_A_STAT: rd_val = {16'h0000, 3'h0, ring_cnt_reg, 1'b0, seq_reg,
                               sms_ok, remote_ok, match_done, match, fu_out};
        `CDB_A_LEN:  rd_val = {19'h0_0000, ini_len_reg, 3'h0, pat_len_reg};
        default: begin
          if (haddr[7:4] == `CDB_A_PAT >> 4) rd_val = pat_w[haddr[3:2]];
          if (haddr[7:4] == `CDB_A_INI >> 4) rd_val = ini_w[haddr[3:2]];
        end
      endcase
    end
  end

  // read data is sampled at the address phase; the status word can change without a write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (take && !hwrite) begin
      hrdata <= rd_val;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      link_reg     <= `CDB_LINK_RST;
      gsm_reg      <= 1'b0;
      permit_reg   <= 1'b0;
      quote_reg    <= 1'b0;
      delay_reg    <= 4'h0;
      ring_lim_reg <= `CDB_RING_RST;
      pin_reg      <= 16'h0000;
      pin_set_reg  <= 1'b0;
      pat_len_reg  <= 5'h00;
      ini_len_reg  <= 5'h00;
      for (int i = 0; i < 4; i++) begin
        pat_w[i] <= 32'h0000_0000;
        ini_w[i] <= 32'h0000_0000;
      end
    end else if (wr) begin
      unique case (a_off_reg)
        `CDB_A_LINK: begin
          if (hwdata[`CDB_F_DEFAULT]) link_reg <= `CDB_LINK_RST;
          else link_reg <= hwdata[4:0];
        end
        `CDB_A_MODE: begin
          gsm_reg      <= hwdata[0];
          permit_reg   <= hwdata[1];
          quote_reg    <= hwdata[2];
          delay_reg    <= (hwdata[19:16] > `CDB_DLY_MAX) ? `CDB_DLY_MAX : hwdata[19:16];
          ring_lim_reg <= clamp5(hwdata[28:24]);
        end
        `CDB_A_PIN: begin
          pin_reg     <= hwdata[15:0];
          pin_set_reg <= hwdata[`CDB_F_PINSET];
        end
        `CDB_A_LEN: begin
          pat_len_reg <= (hwdata[4:0] > 5'(`CDB_PAT_MAX)) ? 5'(`CDB_PAT_MAX) : hwdata[4:0];
          ini_len_reg <= (hwdata[12:8] > 5'(`CDB_INI_MAX)) ? 5'(`CDB_INI_MAX)
                                                           : hwdata[12:8];
        end
        default: begin
          if (a_off_reg[7:4] == `CDB_A_PAT >> 4) pat_w[a_off_reg[3:2]] <= hwdata;
          if (a_off_reg[7:4] == `CDB_A_INI >> 4) ini_w[a_off_reg[3:2]] <= hwdata;
        end
      endcase
    end
  end

  assign remote_ok = !gsm_reg || (permit_reg && pin_set_reg);
  assign sms_ok    = gsm_reg && !permit_reg;

  // ---------------- caller matching and ring counting
  assign pat_flat = {pat_w[3], pat_w[2], pat_w[1], pat_w[0]};

  cdb_matcher #(.PAT_MAX(`CDB_PAT_MAX)) u_match (
    .clk     (hclk),
    .rst_n   (hresetn),
    .pat     (pat_flat[4*`CDB_PAT_MAX-1:0]),
    .pat_len (pat_len_reg),
    .call    (call),
    .match   (match),
    .done    (match_done)
  );

  // fires once per call, when both the number and the ring count are in
  assign detect = match && ring_cnt_reg >= ring_lim_reg && !fired_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ring_cnt_reg <= 5'h00;
      fired_reg    <= 1'b0;
      call_detect  <= 1'b0;
    end else begin
      call_detect <= detect;
      if (call.hangup) begin
        ring_cnt_reg <= 5'h00;
        fired_reg    <= 1'b0;
      end else begin
        if (call.ring && ring_cnt_reg != 5'h1f) ring_cnt_reg <= ring_cnt_reg + 5'h01;
        if (detect) fired_reg <= 1'b1;
      end
    end
  end

  // ---------------- function unit output
  // retention level is taken one clock after reset release, never under reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      boot_reg <= 1'b1;
      fu_out   <= 1'b0;
    end else begin
      boot_reg <= 1'b0;
      if (reset_in) fu_out <= 1'b0;
      else if (boot_reg) fu_out <= retain_en && nv_out_in;
      else if (enable_in && detect) fu_out <= 1'b1;
    end
  end

  // ---------------- modem initialization sequence
  assign tx_valid = seq_reg == SEQ_INIT || seq_reg == SEQ_PIN;
  assign tx_byte  = (seq_reg == SEQ_PIN) ? pin_byte(idx_reg, quote_reg, pin_reg) :
                    (idx_reg < ini_len_reg) ? ini_w[idx_reg[3:2]][{idx_reg[1:0], 3'h0} +: 8] :
                    `CDB_ASC_CR;
  assign tx_last  = (seq_reg == SEQ_PIN) ? idx_reg == (quote_reg ? 5'h0e : 5'h0c) :
                    idx_reg == ini_len_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      seq_reg     <= SEQ_DELAY;
      sec_cnt_reg <= 28'h000_0000;
      s_cnt_reg   <= 4'h0;
      idx_reg     <= 5'h00;
    end else if (wr && a_off_reg == `CDB_A_MODE && hwdata[`CDB_F_START]) begin
      seq_reg     <= SEQ_DELAY;
      sec_cnt_reg <= 28'h000_0000;
      s_cnt_reg   <= 4'h0;
      idx_reg     <= 5'h00;
    end else begin
      unique case (seq_reg)
        SEQ_DELAY: begin
          if (s_cnt_reg >= delay_reg) begin
            seq_reg <= SEQ_INIT;
          end else if (sec_cnt_reg == 28'(SEC_CYCLES - 1)) begin
            sec_cnt_reg <= 28'h000_0000;
            s_cnt_reg   <= s_cnt_reg + 4'h1;
          end else begin
            sec_cnt_reg <= sec_cnt_reg + 28'h000_0001;
          end
        end
        SEQ_INIT, SEQ_PIN: begin
          if (tx_ready) begin
            idx_reg <= tx_last ? 5'h00 : idx_reg + 5'h01;
            if (tx_last && seq_reg == SEQ_PIN) seq_reg <= SEQ_DONE;
            if (tx_last && seq_reg == SEQ_INIT)
              seq_reg <= (gsm_reg && pin_set_reg) ? SEQ_PIN : SEQ_DONE;
          end
        end
        SEQ_DONE: seq_reg <= SEQ_DONE;
      endcase
    end
  end

  cdb_uart_tx #(.CLK_HZ(CLK_HZ)) u_tx (
    .clk      (hclk),
    .rst_n    (hresetn),
    .cfg      (link_reg),
    .tx_valid (tx_valid),
    .tx_data  (tx_byte),
    .tx_ready (tx_ready),
    .txd      (modem_txd)
  );

  // ---------------- checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_set_on_match: assert property (
    enable_in && !reset_in && !boot_reg && detect |=> fu_out)
    else $error("output not set on enabled match");
  a_hold_disabled: assert property (
    !enable_in && !reset_in && !boot_reg |=> $stable(fu_out))
    else $error("output changed while disabled");
  a_reset_forces: assert property (
    reset_in [*2] |-> !fu_out)
    else $error("output high under reset input");
  a_boot_restore: assert property (
    boot_reg && !reset_in && retain_en |=> fu_out == $past(nv_out_in))
    else $error("retained output not restored");
  a_boot_low: assert property (
    boot_reg && !retain_en |=> !fu_out)
    else $error("output not low after power-up");
  a_rise_cause: assert property (
    $rose(fu_out) |-> $past(boot_reg) || $past(detect && enable_in))
    else $error("output rose without cause");
  a_ring_gate: assert property (
    detect |-> ring_cnt_reg >= ring_lim_reg && ring_lim_reg inside {[1:20]})
    else $error("detect before ring count");
  a_delay_quiet: assert property (
    seq_reg == SEQ_DELAY |-> !tx_valid && (modem_txd || !tx_ready) && delay_reg <= 4'ha)
    else $error("link active during power-up delay");
  a_std_no_sms: assert property (
    !gsm_reg |-> !sms_ok && remote_ok)
    else $error("standard modem allows messages");
  a_remote_pin: assert property (
    gsm_reg && !pin_set_reg |-> !remote_ok)
    else $error("remote access without PIN");
  a_defaults: assert property (
    wr && a_off_reg == `CDB_A_LINK && hwdata[`CDB_F_DEFAULT] |=> link_reg == 5'h00)
    else $error("defaults not restored");

  c_detect:  cover property (enable_in && detect ##1 fu_out);
  c_restore: cover property (boot_reg && retain_en && nv_out_in ##1 fu_out);
  c_pin:     cover property (seq_reg == SEQ_PIN && quote_reg ##[1:1000] seq_reg == SEQ_DONE);
  c_held:    cover property (!enable_in && match && ring_cnt_reg >= ring_lim_reg);
endmodule : cdb_call_detect

// *** verif/cdb_modem_model.sv ***
// modem model: drives caller events and decodes the serial line from the block
// assumes caller events are sampled on the rising edge of clk
`timescale 1ns/1ps
module cdb_modem_model #(
  parameter int CLK_HZ = 192000
) (
  input  wire logic               clk,
  input  wire logic               txd,
  input  wire cdb_pkg::cdb_link_s cfg,
  output cdb_pkg::cdb_call_s      call
);
  import cdb_pkg::*;
  logic [7:0] rx_q[$];
  int         rx_err = 0;
  int         bt;
  logic [7:0] b;
  initial call = '0;
  task automatic pulse(input logic [7:0] v);
    call <= cdb_call_s'(v);
    @(posedge clk);
    call <= '0;
    @(posedge clk);
  endtask : pulse
  task automatic ring_call(input logic [31:0] num, input int n, input int rings);
    pulse(8'h01);
    for (int i = 0; i < n; i++) pulse({2'b01, num[4*i+:4], 2'b00});
    pulse(8'h02);
    repeat (rings) pulse(8'h80);
  endtask : ring_call
  // format is read after the start edge, so a change between frames is honoured
  initial forever begin
    @(negedge txd);
    bt = CLK_HZ / (cfg.baud_hi ? 19200 : 9600);
    b = '0;
    repeat (bt / 2) @(posedge clk);
    if (txd) rx_err++;
    for (int i = 0; i < (cfg.char7 ? 7 : 8); i++) begin
      repeat (bt) @(posedge clk);
      b[i] = txd;
    end
    if (cfg.parity != PAR_NONE) begin
      repeat (bt) @(posedge clk);
      if ((^b ^ txd) != (cfg.parity == PAR_ODD)) rx_err++;
    end
    repeat (cfg.stop2 ? 2 : 1) begin
      repeat (bt) @(posedge clk);
      if (!txd) rx_err++;
    end
    rx_q.push_back(b);
  end
endmodule : cdb_modem_model

// *** verif/call_detect_block_bench.sv ***
// self-checking bench of the call detect block with a modem model on its serial side
// assumes package, header and design are compiled first
`timescale 1ns/1ps
`include "cdb_regs.svh"
module call_detect_block_bench;
  import cdb_pkg::*;
  typedef struct packed {
    logic [31:0] pat;
    logic [4:0]  plen;
    logic [31:0] num;
    logic [3:0]  nlen;
    logic        hit;
  } cdb_row_s;
  // nibble codes low first: a plus, c asterisk
  cdb_row_s rows [10] = '{
    '{32'h0000_0765, 5'h03, 32'h0000_0765, 4'h3, 1'b1},
    '{32'h0000_0765, 5'h03, 32'h0000_0865, 4'h3, 1'b0},
    '{32'h0000_0765, 5'h03, 32'h0000_8765, 4'h4, 1'b0},
    '{32'h0000_0765, 5'h03, 32'h0000_0000, 4'h0, 1'b0},
    '{32'h0000_c765, 5'h04, 32'h0000_0765, 4'h3, 1'b0},
    '{32'h0000_0065, 5'h02, 32'h0000_0765, 4'h3, 1'b0},
    '{32'h0000_0c65, 5'h03, 32'h0000_0765, 4'h3, 1'b1},
    '{32'h0000_000c, 5'h01, 32'h0000_0005, 4'h1, 1'b1},
    '{32'h0000_00ca, 5'h02, 32'h0000_094a, 4'h3, 1'b1},
    '{32'h0000_00ca, 5'h02, 32'h0000_0094, 4'h2, 1'b0}};
  logic [31:0] rm [4] = '{32'h0100_0000, 32'h0100_0001, 32'h0100_0003, 32'h0100_0003};
  logic [31:0] rp [4] = '{32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0001_0000};
  logic [1:0]  re [4] = '{2'h2, 2'h1, 2'h0, 2'h2};
  string       tx_s   = "AT\rAT+CPIN=\"1234\"\r";
  logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, enable_in = 1, reset_in = 0;
  logic        retain_en = 0, nv_out_in = 0, hreadyout, hresp;
  logic        fu_out, call_detect, remote_ok, sms_ok, modem_txd;
  logic [1:0]  htrans = '0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, r, d0, det_cnt = '0;
  cdb_call_s   call;
  cdb_link_s   link = '0;
  int          fails = 0, tests_run = 0, lo;
  always #2.5 hclk = ~hclk;
  always @(posedge hclk) if (call_detect === 1'b1) det_cnt <= det_cnt + 1;
  // a small clock figure keeps a bit at 20 or 10 cycles and a second at 50
  cdb_call_detect #(.CLK_HZ(192000), .SEC_CYCLES(50)) u_dut (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .call, .enable_in, .reset_in,
    .retain_en, .nv_out_in, .fu_out, .call_detect, .remote_ok, .sms_ok, .modem_txd);
  cdb_modem_model #(.CLK_HZ(192000)) u_modem (.clk(hclk), .txd(modem_txd), .cfg(link), .call);
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= {24'h00_0000, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
    chk("hresp", hresp, 0);
  endtask : bus
  task automatic call_chk(input logic [31:0] num, input int n, input int k);
    u_modem.ring_call(num, n, k);
    repeat (3) @(posedge hclk);
  endtask : call_chk
  task automatic wait_rx(input int n);
    for (int k = 0; k < 9000 && u_modem.rx_q.size() < n; k++) @(posedge hclk);
  endtask : wait_rx
  task automatic summarize;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize
  initial begin
    repeat (40000) @(posedge hclk);
    fails++;
    summarize();
  end
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    chk("fu_out", fu_out, 0);
    chk("txd idle", modem_txd, 1);
    bus(`CDB_A_LINK, 0, 0);
    chk("link", r, 0);
    bus(8'h44, 1, 32'hffff_ffff);
    bus(8'h44, 0, 0);
    chk("unmapped", r, 0);
    bus(`CDB_A_MODE, 1, 32'h0100_0000);
    $display("test reset done");
    foreach (rows[i]) begin
      bus(`CDB_A_PAT, 1, rows[i].pat);
      bus(`CDB_A_LEN, 1, {27'h000_0040, rows[i].plen});
      reset_in <= 1'b1;
      @(posedge hclk);
      reset_in <= 1'b0;
      d0 = det_cnt;
      call_chk(rows[i].num, rows[i].nlen, 1);
      chk("row out", fu_out, rows[i].hit);
      chk("row det", det_cnt - d0, rows[i].hit);
    end
    $display("test rows done");
    bus(`CDB_A_PAT, 1, 32'h0000_0765);
    bus(`CDB_A_LEN, 1, 32'h0000_0203);
    enable_in <= 1'b0;
    d0 = det_cnt;
    call_chk(32'h0000_0765, 3, 1);
    chk("hold low", fu_out, 0);
    chk("consumed", det_cnt - d0, 1);
    enable_in <= 1'b1;
    call_chk(32'h0000_0765, 3, 1);
    chk("set", fu_out, 1);
    enable_in <= 1'b0;
    repeat (3) @(posedge hclk);
    chk("hold high", fu_out, 1);
    reset_in <= 1'b1;
    repeat (2) @(posedge hclk);
    chk("reset", fu_out, 0);
    reset_in <= 1'b0;
    enable_in <= 1'b1;
    bus(`CDB_A_MODE, 1, 32'h0300_0000);
    call_chk(32'h0000_0765, 3, 2);
    chk("two rings", fu_out, 0);
    u_modem.pulse(8'h80);
    repeat (2) @(posedge hclk);
    chk("three rings", fu_out, 1);
    $display("test unit done");
    for (int i = 0; i < 4; i++) begin
      bus(`CDB_A_PIN, 1, rp[i]);
      bus(`CDB_A_MODE, 1, rm[i]);
      @(posedge hclk);
      chk("remote", remote_ok, re[i][1]);
      chk("sms", sms_ok, re[i][0]);
    end
    $display("test remote done");
    u_modem.rx_q.delete();
    bus(`CDB_A_LINK, 1, 32'h0000_001b);
    bus(`CDB_A_LINK, 1, 32'h0000_011b);
    bus(`CDB_A_LINK, 0, 0);
    chk("defaults", r, 0);
    bus(`CDB_A_INI, 1, 32'h0000_5441);
    bus(`CDB_A_MODE, 1, 32'h0102_0100);
    lo = 0;
    repeat (95) begin
      @(posedge hclk);
      if (modem_txd !== 1'b1) lo++;
    end
    chk("delay", lo, 0);
    wait_rx(3);
    for (int i = 0; i < 3; i++) chk("init byte", u_modem.rx_q[i], tx_s[i]);
    u_modem.rx_q.delete();
    link <= cdb_link_s'(5'h1b);
    bus(`CDB_A_LINK, 1, 32'h0000_001b);
    bus(`CDB_A_PIN, 1, 32'h0001_4321);
    bus(`CDB_A_MODE, 1, 32'h0100_0105);
    wait_rx(18);
    for (int i = 0; i < 18; i++) chk("pin byte", u_modem.rx_q[i], tx_s[i]);
    chk("frames", u_modem.rx_err, 0);
    $display("test link done");
    hresetn <= 1'b0;
    retain_en <= 1'b1;
    nv_out_in <= 1'b1;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    chk("retained", fu_out, 1);
    $display("test retain done");
    summarize();
  end
endmodule : call_detect_block_bench
